//--- rtl/mps_defs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MPS_ADDR_CTRL 8'h00
`define MPS_ADDR_PERIOD 8'h04
`define MPS_ADDR_ONTIME 8'h08
`define MPS_ADDR_STATUS 8'h0c
`define MPS_ADDR_IRQ_STATUS 8'h10
`define MPS_ADDR_IRQ_MASK 8'h14
`define MPS_ADDR_REF 8'h18

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define MPS_CTRL_RUN 0
`define MPS_CTRL_FCLR 1
`define MPS_IRQ_W 3
`define MPS_IRQ_OC 0
`define MPS_IRQ_PGFALL 1
`define MPS_IRQ_SSDONE 2
`define MPS_PERIOD_RST 16'h0064
`define MPS_ONTIME_RST 16'h0000
`define MPS_PERIOD_MIN 16'h0006

// ----------------------------------------------------------------------
// Timing and decode constants
// ----------------------------------------------------------------------
`define MPS_NCH 3
`define MPS_DUTY_MAX_PCT 32'd66
`define MPS_ALT_BASE_MV 12'd800
`define MPS_ALT_STEP_MV 12'd25
`define MPS_ALT_TOP_CODE 5'h1e
`define MPS_ALT_OFF_CODE 5'h1f

`endif

//--- rtl/mps_pkg.sv
// Types shared by the sequencer modules
package mps_pkg;
  typedef enum logic [2:0] {
    FAM_NEW6 = 3'b001,
    FAM_OLD5 = 3'b010,
    FAM_ALT5 = 3'b100
  } mps_family_t;

  typedef enum logic [2:0] {
    MODE_1CH = 3'b001,
    MODE_2CH = 3'b010,
    MODE_3CH = 3'b100
  } mps_mode_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_SOFT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_FAULT = 4'b1000
  } mps_state_t;
endpackage

//--- rtl/mps_chan_if.sv
// Carrier between the sequencer core and one channel
`timescale 1ns/100ps
`default_nettype none
interface mps_chan_if #(parameter int CW = 16);
  logic [CW-1:0] cnt;
  logic [CW-1:0] period;
  logic [CW-1:0] offset;
  logic [CW-1:0] onCycles;
  logic [CW-1:0] minOff;
  logic run;
  logic active;
  logic pulse;
  logic upper;
  logic lower;
  modport core (output cnt, period, offset, onCycles, minOff, run, active,
                input pulse, upper, lower);
  modport chan (input cnt, period, offset, onCycles, minOff, run, active,
                output pulse, upper, lower);
endinterface
`default_nettype wire

//--- rtl/mps_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module mps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;

  initial begin
    if (W < 1) $error("mps_sync: W must be at least 1");
  end

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end
endmodule // mps_sync
`default_nettype wire

//--- rtl/mps_channel.sv
// One interleaved channel: pulse timing and non-overlapping gate drive
`timescale 1ns/100ps
`default_nettype none
module mps_channel (
  input wire logic clk,
  input wire logic sys_rst,
  mps_chan_if.chan ch
);
  localparam int CW = $bits(ch.cnt);
  logic [CW-1:0] pos;
  logic [CW-1:0] riseAt;
  logic pulse_r, pulse_nxt, upper_r, upper_nxt, lower_r, lower_nxt;
  logic live;

  always_comb begin
    // Position since this channel's own termination point
    if (ch.cnt >= ch.offset) begin
      pos = ch.cnt - ch.offset;
    end else begin
      pos = CW'(ch.cnt + ch.period - ch.offset);
    end
    riseAt = ch.period - ch.onCycles;
    live = ch.run && ch.active;
    pulse_nxt = pulse_r;
    if (!live || pos == '0) begin
      pulse_nxt = 1'b0;
    end else if (!pulse_r && ch.onCycles != '0 && pos >= ch.minOff && pos >= riseAt) begin
      pulse_nxt = 1'b1;
    end
    // Each gate waits for the other to be seen off first
    upper_nxt = pulse_r && !lower_r;
    lower_nxt = live && !pulse_r && !upper_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulse_r <= 1'b0;
      upper_r <= 1'b0;
      lower_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
    end
  end

  assign ch.pulse = pulse_r;
  assign ch.upper = upper_r;
  assign ch.lower = lower_r;
endmodule // mps_channel
`default_nettype wire

//--- rtl/multiphase_pwm_sequencer.sv
// Multiphase PWM sequencer core with AHB-Lite register slave
//
// Functional notes
// - Third supply absent, second present: two-channel mode, channel three idle.
// - Second and third supplies absent: single-channel mode, channel one only.
// - Enable input low stops all operation; high allows it.
// - Family select high: use six-bit newest code family.
// - Family select low: alternate select low gives vendor family, high older.
// - Decode voltage code per selected family into target reference level.
// - No channel's upper-gate on time exceeds 66 percent of period.
// - Power-good low when outside voltage window or on overcurrent.
// - Power-good held low until soft-start completes.
// - Current sum above overcurrent threshold triggers overcurrent protection.
// - Three-channel mode spaces terminations one third period apart.
// - Lower and upper gates of a channel never on together.
// - Two-channel mode ends channel two half a period after one.
// - Pulse held low at least one third period after termination.
`include "mps_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module multiphase_pwm_sequencer #(
  parameter int CW = 16,
  parameter int AW = 10,
  parameter int SOFTSTART_CYCLES = 20000,
  parameter logic [11:0] OLD_BASE_MV = 12'd1850,
  parameter logic [11:0] OLD_STEP_MV = 12'd25,
  parameter logic [11:0] NEW_BASE_MV = 12'd1600,
  parameter logic [11:0] NEW_STEP_MV = 12'd12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ch2DriverSupply,
  input wire logic ch3DriverSupply,
  input wire logic controllerEnableIn,
  input wire logic familySelect,
  input wire logic altFamilySelect,
  input wire logic [4:0] voltageCode,
  input wire logic overVoltageIn,
  input wire logic underVoltageIn,
  input wire logic [AW-1:0] currentSumLevel,
  input wire logic [AW-1:0] overcurrentThreshold,
  output logic [`MPS_NCH-1:0] upperGate,
  output logic [`MPS_NCH-1:0] lowerGate,
  output logic [`MPS_NCH-1:0] pulseOut,
  output logic powerGoodOut,
  output logic [11:0] refLevel,
  output mps_pkg::mps_family_t familyOut,
  output logic irq
);
  import mps_pkg::*;

  initial begin
    if (CW < 8 || CW > 16) $error("multiphase_pwm_sequencer: CW must be 8..16");
    if (AW < 1 || AW > 32) $error("multiphase_pwm_sequencer: AW must be 1..32");
    if (SOFTSTART_CYCLES < 1) $error("multiphase_pwm_sequencer: bad SOFTSTART_CYCLES");
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [11:0] pinsRaw, pinsSync;
  logic ch2Pres, ch3Pres, enPin, famSel, altSel, ovSync, uvSync;
  logic [4:0] codeSync;

  assign pinsRaw = {ch2DriverSupply, ch3DriverSupply, controllerEnableIn, familySelect,
                    altFamilySelect, voltageCode, overVoltageIn, underVoltageIn};
  mps_sync #(.W(12)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(pinsRaw),
    .dout(pinsSync)
  );
  assign {ch2Pres, ch3Pres, enPin, famSel, altSel, codeSync, ovSync, uvSync} = pinsSync;

  // ------------------------------------------------------------------
  // Register state and AHB-Lite slave
  // ------------------------------------------------------------------
  logic runEn_r, runEn_nxt;
  logic [CW-1:0] period_r, period_nxt, onTime_r, onTime_nxt;
  logic [`MPS_IRQ_W-1:0] irqSt_r, irqSt_nxt, irqMask_r, irqMask_nxt, irqEv;
  logic wrPend_r, wrPend_nxt, rdPend_r, rdPend_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] hrdata_nxt, rdMux;
  logic hreadyout_nxt, faultClr, irq_nxt, accept, wrNow;
  mps_state_t state_r, state_nxt;
  mps_mode_t mode_r, mode_nxt;
  logic power_good_out_nxt;

  assign accept = hsel && htrans[1] && hready;
  assign wrNow = wrPend_r && hready;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (addr_r)
      `MPS_ADDR_CTRL: rdMux[`MPS_CTRL_RUN] = runEn_r;
      `MPS_ADDR_PERIOD: rdMux[CW-1:0] = period_r;
      `MPS_ADDR_ONTIME: rdMux[CW-1:0] = onTime_r;
      `MPS_ADDR_STATUS: rdMux[13:0] = {state_r, mode_r, familyOut, ocLatch(state_r),
                                       powerGoodOut, irq, runEn_r};
      `MPS_ADDR_IRQ_STATUS: rdMux[`MPS_IRQ_W-1:0] = irqSt_r;
      `MPS_ADDR_IRQ_MASK: rdMux[`MPS_IRQ_W-1:0] = irqMask_r;
      `MPS_ADDR_REF: rdMux[11:0] = refLevel;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  function automatic logic ocLatch(input mps_state_t s);
    ocLatch = (s == ST_FAULT);
  endfunction

  always_comb begin
    wrPend_nxt = 1'b0;
    rdPend_nxt = 1'b0;
    addr_nxt = addr_r;
    hreadyout_nxt = 1'b1;
    hrdata_nxt = hrdata;
    runEn_nxt = runEn_r;
    period_nxt = period_r;
    onTime_nxt = onTime_r;
    irqMask_nxt = irqMask_r;
    faultClr = 1'b0;
    irqSt_nxt = irqSt_r;
    // Reads take one wait state so a write just before is seen
    if (rdPend_r) begin
      hrdata_nxt = rdMux;
    end else if (accept) begin
      addr_nxt = haddr[7:0];
      wrPend_nxt = hwrite;
      rdPend_nxt = !hwrite;
      hreadyout_nxt = hwrite;
    end
    if (wrNow) begin
      case (addr_r)
        `MPS_ADDR_CTRL: begin
          runEn_nxt = hwdata[`MPS_CTRL_RUN];
          faultClr = hwdata[`MPS_CTRL_FCLR];
        end
        `MPS_ADDR_PERIOD: period_nxt = hwdata[CW-1:0];
        `MPS_ADDR_ONTIME: onTime_nxt = hwdata[CW-1:0];
        `MPS_ADDR_IRQ_STATUS: irqSt_nxt = irqSt_r & ~hwdata[`MPS_IRQ_W-1:0];
        `MPS_ADDR_IRQ_MASK: irqMask_nxt = hwdata[`MPS_IRQ_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    irqSt_nxt = irqSt_nxt | irqEv;
    irq_nxt = |(irqSt_nxt & irqMask_nxt);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
      runEn_r <= 1'b0;
      period_r <= CW'(`MPS_PERIOD_RST);
      onTime_r <= CW'(`MPS_ONTIME_RST);
      irqSt_r <= '0;
      irqMask_r <= '0;
      irq <= 1'b0;
    end else begin
      wrPend_r <= wrPend_nxt;
      rdPend_r <= rdPend_nxt;
      addr_r <= addr_nxt;
      hreadyout <= hreadyout_nxt;
      hrdata <= hrdata_nxt;
      hresp <= 1'b0;
      runEn_r <= runEn_nxt;
      period_r <= period_nxt;
      onTime_r <= onTime_nxt;
      irqSt_r <= irqSt_nxt;
      irqMask_r <= irqMask_nxt;
      irq <= irq_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Reference family select and code decode
  // ------------------------------------------------------------------
  mps_family_t fam_nxt;
  logic [11:0] ref_nxt;
  logic [5:0] code6;

  always_comb begin
    code6 = {codeSync, altSel};
    if (famSel) begin
      fam_nxt = FAM_NEW6;
    end else if (!altSel) begin
      fam_nxt = FAM_ALT5;
    end else begin
      fam_nxt = FAM_OLD5;
    end
    case (fam_nxt)
      FAM_ALT5: begin
        if (codeSync == `MPS_ALT_OFF_CODE) begin
          ref_nxt = 12'd0;
        end else begin
          ref_nxt = 12'(`MPS_ALT_BASE_MV + `MPS_ALT_STEP_MV
                        * 12'(`MPS_ALT_TOP_CODE - codeSync));
        end
      end
      FAM_OLD5: ref_nxt = 12'(OLD_BASE_MV - OLD_STEP_MV * 12'(codeSync));
      FAM_NEW6: ref_nxt = 12'(NEW_BASE_MV - NEW_STEP_MV * 12'(code6));
      default: ref_nxt = 12'd0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      familyOut <= FAM_NEW6;
      refLevel <= 12'd0;
    end else begin
      familyOut <= fam_nxt;
      refLevel <= ref_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Control state machine, soft-start and power-good
  // ------------------------------------------------------------------
  localparam logic [31:0] SS_LAST = 32'(SOFTSTART_CYCLES - 1);
  logic [31:0] ssCnt_r, ssCnt_nxt;
  logic enable, ocNow, running;

  assign enable = enPin && runEn_r;
  assign ocNow = currentSumLevel > overcurrentThreshold;

  always_comb begin
    state_nxt = state_r;
    ssCnt_nxt = ssCnt_r;
    mode_nxt = mode_r;
    irqEv = '0;
    case (state_r)
      ST_OFF: begin
        ssCnt_nxt = 32'd0;
        // Channel count is only taken while idle, never mid-run
        if (ch3Pres) begin
          mode_nxt = MODE_3CH;
        end else if (ch2Pres) begin
          mode_nxt = MODE_2CH;
        end else begin
          mode_nxt = MODE_1CH;
        end
        if (enable) state_nxt = ST_SOFT;
      end
      ST_SOFT: begin
        ssCnt_nxt = ssCnt_r + 32'd1;
        if (!enable) begin
          state_nxt = ST_OFF;
        end else if (ocNow) begin
          state_nxt = ST_FAULT;
          irqEv[`MPS_IRQ_OC] = 1'b1;
        end else if (ssCnt_r >= SS_LAST) begin
          state_nxt = ST_RUN;
          irqEv[`MPS_IRQ_SSDONE] = 1'b1;
        end
      end
      ST_RUN: begin
        if (!enable) begin
          state_nxt = ST_OFF;
        end else if (ocNow) begin
          state_nxt = ST_FAULT;
          irqEv[`MPS_IRQ_OC] = 1'b1;
        end
      end
      ST_FAULT: begin
        if (!enable || faultClr) state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
    power_good_out_nxt = (state_nxt == ST_RUN) && !ovSync && !uvSync && !ocNow;
    irqEv[`MPS_IRQ_PGFALL] = powerGoodOut && !power_good_out_nxt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_OFF;
      ssCnt_r <= 32'd0;
      mode_r <= MODE_3CH;
      powerGoodOut <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ssCnt_r <= ssCnt_nxt;
      mode_r <= mode_nxt;
      powerGoodOut <= power_good_out_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Period counter and per-channel timing
  // ------------------------------------------------------------------
  logic [CW-1:0] cnt_r, cnt_nxt, periodEff, third, twoThird, half, minOff, maxOn, onEff;

  assign running = (state_r == ST_SOFT) || (state_r == ST_RUN);

  always_comb begin
    // Short periods would collapse the phase offsets onto each other
    periodEff = (period_r < CW'(`MPS_PERIOD_MIN)) ? CW'(`MPS_PERIOD_MIN) : period_r;
    third = CW'(32'(periodEff) / 32'd3);
    twoThird = CW'((32'(periodEff) * 32'd2) / 32'd3);
    half = periodEff >> 1;
    minOff = CW'((32'(periodEff) + 32'd2) / 32'd3);
    maxOn = CW'((32'(periodEff) * `MPS_DUTY_MAX_PCT) / 32'd100);
    onEff = (onTime_r > maxOn) ? maxOn : onTime_r;
    if (!running || cnt_r >= periodEff - CW'(1)) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MPS_NCH; gi++) begin : g_ch
      mps_chan_if #(.CW(CW)) chIf ();
      assign chIf.cnt = cnt_r;
      assign chIf.period = periodEff;
      assign chIf.onCycles = onEff;
      assign chIf.minOff = minOff;
      assign chIf.run = running;
      if (gi == 0) begin : g_off
        assign chIf.offset = '0;
        assign chIf.active = 1'b1;
      end else if (gi == 1) begin : g_off
        assign chIf.offset = (mode_r == MODE_2CH) ? half : third;
        assign chIf.active = (mode_r != MODE_1CH);
      end else begin : g_off
        assign chIf.offset = twoThird;
        assign chIf.active = (mode_r == MODE_3CH);
      end
      mps_channel u_ch (
        .clk(clk),
        .sys_rst(sys_rst),
        .ch(chIf)
      );
      assign upperGate[gi] = chIf.upper;
      assign lowerGate[gi] = chIf.lower;
      assign pulseOut[gi] = chIf.pulse;
    end
  endgenerate

  logic unusedBits;
  assign unusedBits = ^{haddr[31:8], hsize};
endmodule // multiphase_pwm_sequencer
`default_nettype wire

//--- dv/mps_power_stage.sv
// Output stage model feeding the current sum back to the sequencer
`timescale 1ns/100ps
`default_nettype none
module mps_power_stage #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic [2:0] upperGate,
  input wire logic [AW-1:0] load,
  output logic [AW-1:0] currentSumLevel
);
  // Each conducting upper switch adds one step, so the sum moves with switching
  always_ff @(posedge clk) begin
    currentSumLevel <= load + AW'($countones(upperGate));
  end
endmodule // mps_power_stage
`default_nettype wire

//--- dv/mps_seq_props.sv
// Port-level property checker for the multiphase sequencer
`timescale 1ns/100ps
`default_nettype none
`include "mps_defs.svh"
module mps_seq_props #(
  parameter int AW = 10,
  parameter int SOFTSTART_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ch2DriverSupply,
  input wire logic ch3DriverSupply,
  input wire logic controllerEnableIn,
  input wire logic familySelect,
  input wire logic altFamilySelect,
  input wire logic [4:0] voltageCode,
  input wire logic overVoltageIn,
  input wire logic underVoltageIn,
  input wire logic [AW-1:0] currentSumLevel,
  input wire logic [AW-1:0] overcurrentThreshold,
  input wire logic [`MPS_NCH-1:0] upperGate,
  input wire logic [`MPS_NCH-1:0] lowerGate,
  input wire logic powerGoodOut,
  input wire logic [11:0] refLevel,
  input wire logic [2:0] familyOut
);
  import mps_pkg::*;
  logic [31:0] actCnt_r;
  logic [31:0] actCnt_nxt;
  logic idle_r;
  logic idle_nxt;
  // --------------------------------------------------------------
  // Switching activity age
  // --------------------------------------------------------------
  // A single dead cycle is normal, so two quiet cycles mean stopped
  always_comb begin
    idle_nxt = ({upperGate, lowerGate} == '0);
    actCnt_nxt = (idle_nxt && idle_r) ? 32'h0 : actCnt_r + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      actCnt_r <= 32'h0;
      idle_r <= 1'b1;
    end else begin
      actCnt_r <= actCnt_nxt;
      idle_r <= idle_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_oc;
    currentSumLevel > overcurrentThreshold;
  endsequence
  sequence s_famLow;
    (!familySelect && $stable(altFamilySelect)) [*5];
  endsequence
  property p_enableStop;
    !controllerEnableIn [*7] |-> ({upperGate, lowerGate} == '0);
  endproperty
  property p_ch3Idle;
    !ch3DriverSupply [*6] |-> !upperGate[2] && !lowerGate[2];
  endproperty
  property p_ch2Idle;
    (!ch2DriverSupply && !ch3DriverSupply) [*6] |-> !upperGate[1] && !lowerGate[1];
  endproperty
  property p_famNew;
    familySelect [*5] |-> familyOut == FAM_NEW6;
  endproperty
  property p_famLow;
    s_famLow |-> familyOut == (altFamilySelect ? FAM_OLD5 : FAM_ALT5);
  endproperty
  property p_altRef;
    s_famLow and (!altFamilySelect && $stable(voltageCode)) [*5] |-> refLevel ==
      ((voltageCode == 5'h1f) ? 12'h0 : 12'd800 + 12'd25 * (12'd30 - 12'(voltageCode)));
  endproperty
  property p_ocPgood;
    s_oc |=> !powerGoodOut;
  endproperty
  property p_ocGates;
    s_oc |-> ##[1:4] ({upperGate, lowerGate} == '0);
  endproperty
  property p_windowPgood;
    (overVoltageIn || underVoltageIn) [*5] |-> !powerGoodOut;
  endproperty
  property p_pgSoft;
    powerGoodOut |-> actCnt_r >= SOFTSTART_CYCLES / 2;
  endproperty
  property p_noOverlap;
    ((upperGate | $past(upperGate)) & (lowerGate | $past(lowerGate))) == '0;
  endproperty
  a_enableStop: assert property (p_enableStop) else $error("gates on while disabled");
  a_ch3Idle: assert property (p_ch3Idle) else $error("channel three switching");
  a_ch2Idle: assert property (p_ch2Idle) else $error("channel two switching");
  a_famNew: assert property (p_famNew) else $error("family not newest");
  a_famLow: assert property (p_famLow) else $error("wrong five-bit family");
  a_altRef: assert property (p_altRef) else $error("reference level wrong");
  a_ocPgood: assert property (p_ocPgood) else $error("power good kept on trip");
  a_ocGates: assert property (p_ocGates) else $error("gates on after trip");
  a_windowPgood: assert property (p_windowPgood) else $error("power good outside window");
  a_pgSoft: assert property (p_pgSoft) else $error("power good before soft-start");
  a_noOverlap: assert property (p_noOverlap) else $error("gate overlap");
endmodule // mps_seq_props
bind multiphase_pwm_sequencer mps_seq_props #(.AW(AW), .SOFTSTART_CYCLES(SOFTSTART_CYCLES))
  mps_seq_props_i (.clk, .sys_rst, .ch2DriverSupply, .ch3DriverSupply, .controllerEnableIn,
  .familySelect, .altFamilySelect, .voltageCode, .overVoltageIn, .underVoltageIn,
  .currentSumLevel, .overcurrentThreshold, .upperGate, .lowerGate, .powerGoodOut, .refLevel,
  .familyOut);
`default_nettype wire

//--- dv/test_multiphase_pwm_sequencer.sv
// Self-checking bench for the multiphase PWM sequencer
`timescale 1ns/100ps
`default_nettype none
`include "mps_defs.svh"
module test_multiphase_pwm_sequencer;
  import mps_pkg::*;
  localparam int P = 6;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ch2DriverSupply = 1'b0;
  logic ch3DriverSupply = 1'b0;
  logic controllerEnableIn = 1'b0;
  logic familySelect = 1'b1;
  logic altFamilySelect = 1'b1;
  logic [4:0] voltageCode = 5'h0;
  logic overVoltageIn = 1'b0;
  logic underVoltageIn = 1'b0;
  logic [9:0] sumLoad = 10'h0;
  logic [9:0] currentSumLevel;
  logic [9:0] overcurrentThreshold = 10'h3ff;
  logic [2:0] upperGate;
  logic [2:0] lowerGate;
  logic [2:0] pulseOut;
  logic powerGoodOut;
  logic [11:0] refLevel;
  mps_family_t familyOut;
  logic irq;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] expQ[$];
  logic [31:0] seed = 32'h9cd5;
  logic rdPh = 1'b0;
  int hiCnt[3] = '{0, 0, 0};
  int loCnt[3] = '{0, 0, 0};

  multiphase_pwm_sequencer #(.SOFTSTART_CYCLES(20)) multiphase_pwm_sequencer_i (.clk, .sys_rst,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .ch2DriverSupply, .ch3DriverSupply, .controllerEnableIn, .familySelect,
    .altFamilySelect, .voltageCode, .overVoltageIn, .underVoltageIn, .currentSumLevel,
    .overcurrentThreshold, .upperGate, .lowerGate, .pulseOut, .powerGoodOut, .refLevel,
    .familyOut, .irq);
  mps_power_stage #(.AW(10)) mps_power_stage_i (.clk, .upperGate, .load(sumLoad),
    .currentSumLevel);

  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    num_errors++;
    $display("ERROR %0t: wait ran out", $time);
    end_of_test();
  endtask
  // --------------------------------------------------------------
  // Bus master: holds each phase until hready is sampled high
  // --------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    int t;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    for (n = 0; n < 2; n++) begin
      t = 0;
      do begin
        @(posedge clk);
        if (++t > 100) hang();
      end while (hreadyout !== 1'b1);
      // Last edge left free so a following call may start its address phase
      if (n == 0) begin
        htrans <= 2'b00;
        hwdata <= d;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic waitFall(input int k, output int n);
    logic p;
    n = 0;
    p = pulseOut[k];
    forever begin
      @(posedge clk);
      n++;
      if (p === 1'b1 && pulseOut[k] === 1'b0) break;
      if (n > 100) hang();
      p = pulseOut[k];
    end
  endtask
  // Read data is judged at the edge that ends the stretched data phase
  always @(posedge clk) begin
    if (rdPh && hreadyout) begin
      rdPh = 1'b0;
      check(hresp, 1'b0);
      check(hrdata, expQ.pop_front());
    end
    if (hsel && htrans[1] && !hwrite && hreadyout) rdPh = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (hiCnt[k] > 0 && !upperGate[k]) check(hiCnt[k] <= P * 66 / 100, 1);
      if (loCnt[k] > 0 && pulseOut[k]) check(loCnt[k] >= P / 3, 1);
      hiCnt[k] = upperGate[k] ? hiCnt[k] + 1 : 0;
      loCnt[k] = pulseOut[k] ? 0 : loCnt[k] + 1;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    hang();
  end
  initial begin
    logic [4:0] code;
    logic [9:0] t;
    int n0;
    int n1;
    int gap;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`MPS_ADDR_PERIOD, 32'h64);
    rd(`MPS_ADDR_IRQ_MASK, 32'h0);
    rd(8'h1c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      familySelect <= i[1];
      altFamilySelect <= i[0];
      seed = lfsr(seed);
      voltageCode <= seed[4:0];
      repeat (5) @(posedge clk);
      check(familyOut, i[1] ? FAM_NEW6 : i[0] ? FAM_OLD5 : FAM_ALT5);
    end
    familySelect <= 1'b0;
    altFamilySelect <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      code = (i == 0) ? seed[4:0] : 5'h1d + 5'(i);
      voltageCode <= code;
      repeat (5) @(posedge clk);
      rd(`MPS_ADDR_REF, (code == 5'h1f) ? 32'h0 : 32'd800 + 32'd25 * (32'd30 - code));
    end
    familySelect <= 1'b1;
    bus(`MPS_ADDR_PERIOD, 1'b1, P);
    bus(`MPS_ADDR_ONTIME, 1'b1, 32'h5);
    bus(`MPS_ADDR_CTRL, 1'b1, 32'h1);
    for (int m = 0; m < 3; m++) begin
      ch2DriverSupply <= (m > 0);
      ch3DriverSupply <= (m > 1);
      repeat (4) @(posedge clk);
      controllerEnableIn <= 1'b1;
      repeat (12) @(posedge clk);
      check(powerGoodOut, 1'b0);
      repeat (20) @(posedge clk);
      rd(`MPS_ADDR_STATUS, {18'h0, 4'b0100, 3'b001 << m, 3'b001, 4'b0101});
      gap = (m == 0) ? P : (m == 1) ? P / 2 : P / 3;
      waitFall(0, n0);
      for (int k = 1; k <= m; k++) begin
        waitFall(k, n1);
        check(n1, gap);
      end
      waitFall(0, n0);
      check(n0, gap);
      check(pulseOut >> (m + 1), 32'h0);
      if (m < 2) begin
        overVoltageIn <= (m == 0);
        underVoltageIn <= (m == 1);
        repeat (5) @(posedge clk);
        check(powerGoodOut, 1'b0);
        overVoltageIn <= 1'b0;
        underVoltageIn <= 1'b0;
        controllerEnableIn <= 1'b0;
        repeat (8) @(posedge clk);
        check({upperGate, lowerGate}, 32'h0);
      end
    end
    seed = lfsr(seed);
    t = 10'h10 + 10'(seed[8:0]);
    overcurrentThreshold <= t;
    sumLoad <= t - 10'd3;
    bus(`MPS_ADDR_IRQ_STATUS, 1'b1, 32'h7);
    bus(`MPS_ADDR_IRQ_MASK, 1'b1, 32'h1);
    rd(`MPS_ADDR_IRQ_STATUS, 32'h0);
    check(irq, 1'b0);
    sumLoad <= t + 10'd1;
    repeat (5) @(posedge clk);
    check({irq, powerGoodOut, upperGate, lowerGate}, 32'h80);
    rd(`MPS_ADDR_IRQ_STATUS, 32'h3);
    bus(`MPS_ADDR_IRQ_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    sumLoad <= t - 10'd3;
    bus(`MPS_ADDR_IRQ_MASK, 1'b1, 32'h1);
    bus(`MPS_ADDR_IRQ_STATUS, 1'b1, 32'h3);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    end_of_test();
  end
endmodule // test_multiphase_pwm_sequencer
`default_nettype wire
